// File: termination_params.svh
// Constants for the I/O bank termination control block.
// Assumes inclusion by bare name from every file that needs them.
`ifndef TERMINATION_PARAMS_SVH
`define TERMINATION_PARAMS_SVH

// Command byte values selecting each termination register.
`define TERM_EN0_OFS       8'h04
`define TERM_EN1_OFS       8'h05
`define TERM_DIR0_OFS      8'h06
`define TERM_DIR1_OFS      8'h07

// Field positions inside an enable register.
`define TERM_BUS_HOLD_BIT  0
`define TERM_PULL_ON_BIT   1

// Reset values.
`define TERM_EN_RST        8'h00
`define TERM_DIR_RST       8'hff

// Default 7-bit target address on the serial bus; the value is arbitrary.
`define TERM_DEV_ADDR      7'h20

// Serial bus bit count of one byte.
`define TERM_BYTE_BITS     4'h8

`endif

// File: termination_pkg.sv
// Types shared by the termination control block and its bank decoder.
// Assumes compilation ahead of every file that imports it.
`default_nettype none
package termination_pkg;

  // Serial target protocol phases.
  typedef enum logic [2:0] {
    st_idle,
    st_addr,
    st_cmd,
    st_write,
    st_read
  } link_state_e;

  // Termination actually applied to the eight pins of one bank.
  typedef struct packed {
    logic       bus_hold;
    logic [7:0] pull_up;
    logic [7:0] pull_down;
  } bank_term_s;

endpackage

`default_nettype wire

// File: bank_termination.sv
// Decodes one bank's enable and pull-direction registers into pin
// termination. Assumes both register values are on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "termination_params.svh"

module bank_termination (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       nrst,
  // Register contents
  input  wire logic [7:0]                 enable_reg,
  input  wire logic [7:0]                 direction_reg,
  // Applied termination
  output var  termination_pkg::bank_term_s term
);
  import termination_pkg::*;

  wire logic       hold_on;
  wire logic       pull_on;
  wire logic [7:0] pull_mask;
  bank_term_s      term_nxt;

  // Bus-hold overrides pulls; upper enable bits reach nothing here.
  assign hold_on   = enable_reg[`TERM_BUS_HOLD_BIT];
  assign pull_on   = ~hold_on & enable_reg[`TERM_PULL_ON_BIT];
  assign pull_mask = {8{pull_on}};

  // A stored direction only reaches the pins through the pull mask.
  assign term_nxt.bus_hold  = hold_on;
  assign term_nxt.pull_up   = direction_reg & pull_mask;
  assign term_nxt.pull_down = ~direction_reg & pull_mask;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      term <= '0;
    end else begin
      term <= term_nxt;
    end
  end

endmodule

`default_nettype wire

// File: io_bank_termination_control.sv
// Serial-bus target holding the termination registers of two 8-pin banks
// and driving the applied bus-hold and pull settings of every pin.
// Assumes scl and sda come from outside the clock domain and that the
// bus clock is slow enough for several clk cycles per bus phase.
//
// What this block does
// - Bank 0 enable bit 0 set turns bus-hold on for all bank 0 pins.
// - Bank 0 bus-hold on forces every bank 0 pull resistor off.
// - Bank 0 pull bit set, hold off: pins follow bank 0 direction bits.
// - Bank 0 pull bit clear: no pulls, bank 0 direction bits ignored.
// - Bank 1 enable bit 0 controls bank 1 bus-hold, disabling its pulls.
// - Bank 1 pull bit applies bank 1 directions only with hold off.
// - Bank 0 direction bit one selects pull-up, zero selects pull-down.
// - Direction writes under bus-hold are stored but change no pin.
// - Reset clears bus-hold and pull enable bits of both banks.
// - Reset sets every bank 0 direction bit, selecting pull-up.
// - Bank 1 direction bits pick pull-up or pull-down when pulls apply.
`timescale 1ns/1ps
`default_nettype none
`include "termination_params.svh"

module io_bank_termination_control #(
  parameter logic [6:0] DEV_ADDR = `TERM_DEV_ADDR
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        nrst,
  // Two-wire serial bus
  input  wire logic                        scl_in,
  input  wire logic                        sda_in,
  output logic                             sda_out,
  output logic                             sda_oe_n,
  // Applied termination
  output var  termination_pkg::bank_term_s bank0_term,
  output var  termination_pkg::bank_term_s bank1_term,
  // Register contents for observation
  output logic [7:0]                       bank0_pull_direction_reg,
  output logic [7:0]                       bank1_pull_direction_reg
);
  import termination_pkg::*;

  // Two-stage synchronisers, plus one more stage for edge detection.
  logic [1:0]  scl_sync_r;
  logic [1:0]  sda_sync_r;
  logic        scl_prev_r;
  logic        sda_prev_r;

  logic [7:0]  bank0_termination_enable_r;
  logic [7:0]  bank1_termination_enable_r;
  logic [7:0]  dir0_r;
  logic [7:0]  dir1_r;

  link_state_e state_r;
  logic [3:0]  bit_cnt_r;
  logic [7:0]  shift_r;
  logic [7:0]  ptr_r;
  logic        ack_phase_r;

  wire logic   scl_s;
  wire logic   sda_s;
  wire logic   scl_rise;
  wire logic   scl_fall;
  wire logic   start_seen;
  wire logic   stop_seen;
  wire logic   byte_done;
  wire logic   addr_match;
  wire logic   wr_strobe;
  wire logic   wr_en0;
  wire logic   wr_en1;
  wire logic   wr_dir0;
  wire logic   wr_dir1;
  wire logic [7:0] rd_data;
  wire logic [7:0] ptr_inc;

  assign scl_s      = scl_sync_r[1];
  assign sda_s      = sda_sync_r[1];
  assign scl_rise   = scl_s & ~scl_prev_r;
  assign scl_fall   = ~scl_s & scl_prev_r;
  assign start_seen = scl_s & scl_prev_r & sda_prev_r & ~sda_s;
  assign stop_seen  = scl_s & scl_prev_r & ~sda_prev_r & sda_s;
  assign byte_done  = scl_fall & ~ack_phase_r
                      & (bit_cnt_r == `TERM_BYTE_BITS);
  assign addr_match = (shift_r[7:1] == DEV_ADDR);
  assign ptr_inc    = ptr_r + 8'h01;

  // A data byte lands only after address and command were taken.
  assign wr_strobe  = byte_done & (state_r == st_write);
  assign wr_en0     = wr_strobe & (ptr_r == `TERM_EN0_OFS);
  assign wr_en1     = wr_strobe & (ptr_r == `TERM_EN1_OFS);
  assign wr_dir0    = wr_strobe & (ptr_r == `TERM_DIR0_OFS);
  assign wr_dir1    = wr_strobe & (ptr_r == `TERM_DIR1_OFS);

  // Command values outside the termination set read as zero.
  assign rd_data =
    (ptr_r == `TERM_EN0_OFS)  ? bank0_termination_enable_r :
    (ptr_r == `TERM_EN1_OFS)  ? bank1_termination_enable_r :
    (ptr_r == `TERM_DIR0_OFS) ? dir0_r :
    (ptr_r == `TERM_DIR1_OFS) ? dir1_r : 8'h00;

  assign sda_out                  = 1'b0;
  assign bank0_pull_direction_reg = dir0_r;
  assign bank1_pull_direction_reg = dir1_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_prev_r <= 1'b1;
      sda_prev_r <= 1'b1;
    end else begin
      scl_sync_r <= {scl_sync_r[0], scl_in};
      sda_sync_r <= {sda_sync_r[0], sda_in};
      scl_prev_r <= scl_s;
      sda_prev_r <= sda_s;
    end
  end

  // The whole byte is stored, so unused upper bits read back as written.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bank0_termination_enable_r <= `TERM_EN_RST;
      bank1_termination_enable_r <= `TERM_EN_RST;
      dir0_r                     <= `TERM_DIR_RST;
      dir1_r                     <= `TERM_DIR_RST;
    end else begin
      if (wr_en0) begin
        bank0_termination_enable_r <= shift_r;
      end
      if (wr_en1) begin
        bank1_termination_enable_r <= shift_r;
      end
      if (wr_dir0) begin
        dir0_r <= shift_r;
      end
      if (wr_dir1) begin
        dir1_r <= shift_r;
      end
    end
  end

  // Protocol engine. Start and stop win over any bit activity, so a
  // repeated start always restarts address collection.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r     <= st_idle;
      bit_cnt_r   <= 4'h0;
      shift_r     <= 8'h00;
      ptr_r       <= 8'h00;
      ack_phase_r <= 1'b0;
      sda_oe_n    <= 1'b1;
    end else if (start_seen) begin
      state_r     <= st_addr;
      bit_cnt_r   <= 4'h0;
      ack_phase_r <= 1'b0;
      sda_oe_n    <= 1'b1;
    end else if (stop_seen) begin
      state_r     <= st_idle;
      ack_phase_r <= 1'b0;
      sda_oe_n    <= 1'b1;
    end else if (state_r != st_idle) begin
      if (scl_rise && !ack_phase_r) begin
        shift_r   <= {shift_r[6:0], sda_s};
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end else if (scl_rise && state_r == st_read && sda_s) begin
        // The host declined more data; let go of the bus.
        state_r <= st_idle;
      end else if (byte_done) begin
        bit_cnt_r   <= 4'h0;
        ack_phase_r <= 1'b1;
        unique case (state_r)
          st_addr: begin
            if (addr_match) begin
              sda_oe_n <= 1'b0;
              state_r  <= shift_r[0] ? st_read : st_cmd;
            end else begin
              sda_oe_n <= 1'b1;
              state_r  <= st_idle;
            end
          end
          st_cmd: begin
            ptr_r    <= shift_r;
            sda_oe_n <= 1'b0;
            state_r  <= st_write;
          end
          st_write: begin
            ptr_r    <= ptr_inc;
            sda_oe_n <= 1'b0;
          end
          st_read: begin
            sda_oe_n <= 1'b1;
          end
          st_idle: begin
            sda_oe_n <= 1'b1;
          end
        endcase
      end else if (scl_fall && ack_phase_r) begin
        ack_phase_r <= 1'b0;
        if (state_r == st_read) begin
          shift_r  <= rd_data;
          sda_oe_n <= rd_data[7];
          ptr_r    <= ptr_inc;
        end else begin
          sda_oe_n <= 1'b1;
        end
      end else if (scl_fall && state_r == st_read) begin
        sda_oe_n <= shift_r[7];
      end
    end
  end

  // One decoder per bank keeps the override order identical for both.
  bank_termination u_bank0 (
    .clk           (clk),
    .nrst          (nrst),
    .enable_reg    (bank0_termination_enable_r),
    .direction_reg (dir0_r),
    .term          (bank0_term)
  );

  bank_termination u_bank1 (
    .clk           (clk),
    .nrst          (nrst),
    .enable_reg    (bank1_termination_enable_r),
    .direction_reg (dir1_r),
    .term          (bank1_term)
  );

endmodule

`default_nettype wire

// File: io_bank_termination_props.sv
// Assertions on applied termination and stored direction registers.
// Assumes a bind onto io_bank_termination_control.
`timescale 1ns/1ps
`default_nettype none
module io_bank_termination_props (
  // Clock and reset
  input wire logic                        clk,
  input wire logic                        nrst,
  // Observed outputs
  input wire termination_pkg::bank_term_s bank0_term,
  input wire termination_pkg::bank_term_s bank1_term,
  input wire logic [7:0]                  bank0_pull_direction_reg,
  input wire logic [7:0]                  bank1_pull_direction_reg
);
  import termination_pkg::*;
  wire logic       h0 = bank0_term.bus_hold;
  wire logic       h1 = bank1_term.bus_hold;
  wire logic [7:0] up0 = bank0_term.pull_up;
  wire logic [7:0] dn0 = bank0_term.pull_down;
  wire logic [7:0] up1 = bank1_term.pull_up;
  wire logic [7:0] dn1 = bank1_term.pull_down;
  wire logic [7:0] d0 = bank0_pull_direction_reg;
  wire logic [7:0] d1 = bank1_pull_direction_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_dir0_write_held;
    h0 && $changed(d0);
  endsequence
  a_b0_hold_nopull: assert property (h0 |-> (up0 | dn0) == 8'h0)
    else $error("bank 0 pull on under bus-hold");
  a_b1_hold_nopull: assert property (h1 |-> (up1 | dn1) == 8'h0)
    else $error("bank 1 pull on under bus-hold");
  a_b0_dir_follow: assert property (
    (up0 | dn0) != 8'h0 && $stable(d0) |-> up0 == d0 && dn0 == ~d0)
    else $error("bank 0 pulls differ from direction");
  a_b1_dir_follow: assert property (
    (up1 | dn1) != 8'h0 && $stable(d1) |-> up1 == d1 && dn1 == ~d1)
    else $error("bank 1 pulls differ from direction");
  a_held_dir_write: assert property (
    s_dir0_write_held |=> $stable(bank0_term))
    else $error("direction write moved held bank 0");
  a_reset_dflt: assert property (
    $rose(nrst) |-> {d0, d1} == 16'hffff && {bank0_term, bank1_term} == 34'h0)
    else $error("reset values wrong");
  a_b0_up_down: assert property ((up0 & dn0) == 8'h0)
    else $error("bank 0 pin pulled both ways");
  a_b1_up_down: assert property ((up1 & dn1) == 8'h0)
    else $error("bank 1 pin pulled both ways");
endmodule
`default_nettype wire

// File: serial_host_model.sv
// Two-wire serial host that writes and reads registers by command byte.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none
`include "termination_params.svh"
module serial_host_model (
  // Clock and data wire
  input  wire logic clk,
  input  wire logic sda_wire,
  // Bus lines
  output var  logic scl,
  output var  logic sda_drv
);
  // A 40 ns quarter makes the 160 ns bus period; scl idles high.
  localparam int QTR = 40;
  int nacks = 0;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic bit_out(input logic b);
    sda_drv = b;
    #QTR scl = 1'b1;
    #(2*QTR) scl = 1'b0;
    #QTR;
  endtask
  task automatic bit_in(output logic b);
    sda_drv = 1'b1;
    #QTR scl = 1'b1;
    #QTR b = sda_wire;
    #QTR scl = 1'b0;
    #QTR;
  endtask
  task automatic frame_start();
    sda_drv = 1'b1;
    #QTR scl = 1'b1;
    #QTR sda_drv = 1'b0;
    #QTR scl = 1'b0;
    #QTR;
  endtask
  task automatic frame_stop();
    sda_drv = 1'b0;
    #QTR scl = 1'b1;
    #QTR sda_drv = 1'b1;
    #(2*QTR);
  endtask
  task automatic byte_out(input logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(a);
    if (a) nacks++;
  endtask
  task automatic write_reg(input logic [7:0] cmd, input logic [7:0] d);
    @(posedge clk);
    #1;
    frame_start();
    byte_out({`TERM_DEV_ADDR, 1'b0});
    byte_out(cmd);
    byte_out(d);
    frame_stop();
  endtask
  task automatic read_reg(input logic [7:0] cmd, output logic [7:0] d);
    @(posedge clk);
    #1;
    frame_start();
    byte_out({`TERM_DEV_ADDR, 1'b0});
    byte_out(cmd);
    frame_start();
    byte_out({`TERM_DEV_ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) bit_in(d[i]);
    bit_out(1'b1);
    frame_stop();
  endtask
endmodule
`default_nettype wire

// File: io_bank_termination_control_bench.sv
// Self-checking bench for the termination control block.
// Assumes the serial host model and a pull-up on the data wire.
`timescale 1ns/1ps
`default_nettype none
`include "termination_params.svh"
module io_bank_termination_control_bench;
  import termination_pkg::*;
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  logic       scl, sda_drv, sda_out, sda_oe_n, sda_wire;
  bank_term_s t0, t1;
  logic [7:0] d0, d1, rd;
  int         n_fail = 0;
  int         checks = 0;
  assign sda_wire = sda_drv & (sda_oe_n ? 1'b1 : sda_out);
  always #2.5 clk = ~clk;
  serial_host_model host (.clk(clk), .sda_wire(sda_wire), .scl(scl),
    .sda_drv(sda_drv));
  io_bank_termination_control dut (.clk(clk), .nrst(nrst), .scl_in(scl),
    .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .bank0_term(t0), .bank1_term(t1), .bank0_pull_direction_reg(d0),
    .bank1_pull_direction_reg(d1));
  task automatic check(input string nm, input logic [16:0] s, e);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic results();
    if (n_fail == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic step(input logic [7:0] c, v, input logic b1,
                      input logic [16:0] e);
    host.write_reg(c, v);
    repeat (4) @(posedge clk);
    #1;
    check(b1 ? "term1" : "term0", b1 ? t1 : t0, e);
  endtask
  initial begin
    #300000;
    n_fail++;
    results();
  end
  initial begin
    repeat (4) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check("dir0", d0, 8'hff);
    check("term0", t0, 17'h0);
    check("term1", t1, 17'h0);
    host.read_reg(`TERM_EN1_OFS, rd);
    check("en1", rd[1:0], 2'b00);
    step(`TERM_EN0_OFS, 8'h02, 0, {1'b0, 8'hff, 8'h00});
    step(`TERM_DIR0_OFS, 8'ha5, 0, {1'b0, 8'ha5, 8'h5a});
    step(`TERM_EN0_OFS, 8'h03, 0, {1'b1, 16'h0});
    step(`TERM_DIR0_OFS, 8'h3c, 0, {1'b1, 16'h0});
    check("dir0", d0, 8'h3c);
    step(`TERM_EN0_OFS, 8'h02, 0, {1'b0, 8'h3c, 8'hc3});
    step(`TERM_EN0_OFS, 8'hfe, 0, {1'b0, 8'h3c, 8'hc3});
    step(`TERM_EN0_OFS, 8'hfc, 0, 17'h0);
    host.read_reg(`TERM_EN0_OFS, rd);
    check("en0", rd, 8'hfc);
    step(`TERM_EN1_OFS, 8'h01, 1, {1'b1, 16'h0});
    step(`TERM_DIR1_OFS, 8'h0f, 1, {1'b1, 16'h0});
    step(`TERM_EN1_OFS, 8'h02, 1, {1'b0, 8'h0f, 8'hf0});
    step(`TERM_EN1_OFS, 8'h00, 1, 17'h0);
    check("dir1", d1, 8'h0f);
    host.read_reg(`TERM_DIR1_OFS, rd);
    check("dir1 read", rd, 8'h0f);
    step(`TERM_EN0_OFS, 8'h03, 0, {1'b1, 16'h0});
    // A reset in mid-run must bring back the defaults over written values.
    @(posedge clk);
    #1 nrst = 1'b0;
    repeat (4) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check("dir0", d0, 8'hff);
    check("term0", t0, 17'h0);
    host.read_reg(`TERM_EN0_OFS, rd);
    check("en0", rd[1:0], 2'b00);
    step(`TERM_EN0_OFS, 8'h02, 0, {1'b0, 8'hff, 8'h00});
    check("nacks", 17'(host.nacks), 17'h0);
    results();
  end
endmodule
bind io_bank_termination_control io_bank_termination_props u_props (
  .clk(clk), .nrst(nrst), .bank0_term(bank0_term), .bank1_term(bank1_term),
  .bank0_pull_direction_reg(bank0_pull_direction_reg),
  .bank1_pull_direction_reg(bank1_pull_direction_reg));
`default_nettype wire
